// ### inc/hpp_pkg.sv
// Constants, types and register map of the host parallel port
package hpp_pkg;
  // ==========================================================
  // Register bus
  localparam int         AXI_AW        = 8;
  localparam logic [7:0] OFS_BANK_CTRL = 8'h00;
  localparam logic [7:0] OFS_GPIO_CTRL = 8'h04;
  localparam logic [7:0] OFS_GPIO_DATA = 8'h08;
  localparam logic [7:0] OFS_HOST_CTRL = 8'h0C;
  localparam logic [7:0] OFS_HOST_ADDR = 8'h10;
  localparam logic [1:0] MEM_PAGE      = 2'h1;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // ==========================================================
  // Field positions
  localparam int BIT_HOLDER    = 0;
  localparam int BIT_GPIO_MODE = 0;
  localparam int GPIO_DIR_LSB  = 8;
  localparam int GPIO_IN_LSB   = 8;
  localparam int CTRL_INT_BIT  = 3;
  // ==========================================================
  // Shared memory and host register selects
  localparam int         MEM_WORDS    = 16;
  localparam int         MEM_AW       = 4;
  localparam logic [1:0] SEL_CTRL     = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR     = 2'h2;
  // ==========================================================
  // Timing
  localparam int         CLK_PERIOD_PS = 5000;
  localparam int         BUSY_NS       = 10;
  localparam int         BUSY_CYCLES   = (BUSY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] BUSY_LOAD     = 3'(BUSY_CYCLES);
  // ==========================================================
  // Host access states
  typedef enum logic [1:0] {
    HS_IDLE   = 2'b00,
    HS_ACTIVE = 2'b01,
    HS_BUSY   = 2'b10
  } host_state_t;
endpackage

// ### rtl/data_pin_cell.sv
// One host data pin with drive gating and a bus holder
`timescale 1ns/100ps
module data_pin_cell (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin side
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      hold_out,
  output logic      hold_oe,
  // Control
  input  wire logic drive_en,
  input  wire logic drive_val,
  input  wire logic holder_en
);
  logic level_reg;
  logic level_next;

  // Keeper tracks the resolved pin level every cycle
  always_comb begin
    level_next = pin_in;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
    end
  end

  // Holder only acts while nobody inside drives the pin
  assign pin_out  = drive_val;
  assign pin_oe   = drive_en;
  assign hold_out = level_reg;
  assign hold_oe  = holder_en & ~drive_en;

  a_holder_keeps: assert property (@(posedge clk) disable iff (rst)
    hold_oe |-> hold_out == $past(pin_in))
    else $error("holder does not keep last pin level");
  a_holder_excl: assert property (@(posedge clk) disable iff (rst)
    !(hold_oe && pin_oe))
    else $error("holder fights driver");
endmodule

// ### rtl/host_port.sv
// Host parallel port: pin handshake, byte pairing, registers and AXI4-Lite slave
`timescale 1ns/100ps
module host_port
  import hpp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // AXI4-Lite slave
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Host control inputs
  input  wire logic              register_select_lo,
  input  wire logic              register_select_hi,
  input  wire logic              byte_identify,
  input  wire logic              port_select_n,
  input  wire logic              data_strobe_a_n,
  input  wire logic              data_strobe_b_n,
  input  wire logic              read_not_write,
  input  wire logic              address_strobe_n,
  input  wire logic              port_enable_strap,
  input  wire logic              emulation_off_n,
  // Host data bus
  input  wire logic [7:0]        host_data_in,
  output logic [7:0]             host_data_out,
  output logic [7:0]             host_data_oe,
  output logic [7:0]             holder_out,
  output logic [7:0]             holder_oe,
  // Host status outputs
  output logic                   transfer_ready_out,
  output logic                   transfer_ready_oe,
  output logic                   host_interrupt_out,
  output logic                   host_interrupt_oe,
  output logic                   pullup_enable
);
  // ==========================================================
  // State
  logic              aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [AXI_AW-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0]       w_data_reg, w_data_next;
  logic [3:0]        w_strb_reg, w_strb_next;
  logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]       rdata_reg, rdata_next;
  host_state_t       state_reg, state_next;
  logic              strb_d_reg, strb_d_next, as_d_reg, as_d_next;
  logic              strap_reg, strap_next, strap_done_reg, strap_done_next;
  logic [1:0]        acc_sel_reg, acc_sel_next;
  logic              acc_bil_reg, acc_bil_next, acc_rnw_reg, acc_rnw_next;
  logic [7:0]        wr_byte_reg, wr_byte_next, wr_hi_reg, wr_hi_next;
  logic [7:0]        rd_byte_reg, rd_byte_next;
  logic [15:0]       shadow_reg, shadow_next, haddr_reg, haddr_next;
  logic              int_flag_reg, int_flag_next, holder_en_reg, holder_en_next;
  logic              gpio_mode_reg, gpio_mode_next;
  logic [7:0]        gpio_dir_reg, gpio_dir_next, gpio_out_reg, gpio_out_next;
  logic [2:0]        busy_cnt_reg, busy_cnt_next;
  logic [15:0]       mem_reg [MEM_WORDS];
  logic [15:0]       mem_next [MEM_WORDS];
  logic              wr_fire, host_on, sel, strb, start, stop, as_fall;
  logic [31:0]       wr_mask, wr_word;
  logic [1:0]        live_sel;
  logic [15:0]       host_word, ctrl_word;
  logic [7:0]        drive_en;

  // ==========================================================
  // Register read view, shared by reads and masked writes
  function automatic logic [31:0] read_word(input logic [AXI_AW-1:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a[7:6] == MEM_PAGE) begin
      v = {16'h0, mem_reg[a[MEM_AW+1:2]]};
    end else begin
      case ({a[7:2], 2'b00})
        OFS_BANK_CTRL: v[BIT_HOLDER] = holder_en_reg;
        OFS_GPIO_CTRL: v = {16'h0, gpio_dir_reg, 7'h0, gpio_mode_reg};
        OFS_GPIO_DATA: v = {16'h0, host_data_in, gpio_out_reg};
        OFS_HOST_CTRL: v = {16'h0, ctrl_word};
        OFS_HOST_ADDR: v = {16'h0, haddr_reg};
        default:       v = 32'h0;
      endcase
    end
    return v;
  endfunction

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (a[7:6] == MEM_PAGE) || (w == OFS_BANK_CTRL) || (w == OFS_GPIO_CTRL) ||
           (w == OFS_GPIO_DATA) || (w == OFS_HOST_CTRL) || (w == OFS_HOST_ADDR);
  endfunction

  // ==========================================================
  // Pin decode; inputs arrive synchronous to clk
  assign sel      = ~port_select_n;
  assign strb     = sel & (~data_strobe_a_n | ~data_strobe_b_n);
  assign start    = strb & ~strb_d_reg;
  assign stop     = ~strb & strb_d_reg;
  assign as_fall  = ~address_strobe_n & ~as_d_reg;
  assign host_on  = strap_reg & strap_done_reg & ~gpio_mode_reg;
  assign live_sel = {register_select_hi, register_select_lo};
  assign ctrl_word = {12'h0, int_flag_reg, 3'h0};
  assign wr_mask  = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                     {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wr_word  = (read_word(aw_addr_reg) & ~wr_mask) | (w_data_reg & wr_mask);
  assign wr_fire  = aw_held_reg & w_held_reg & ~bvalid_reg;

  // Word the host addresses through the live selects
  always_comb begin
    case (live_sel)
      SEL_CTRL: host_word = ctrl_word;
      SEL_ADDR: host_word = haddr_reg;
      default:  host_word = mem_reg[haddr_reg[MEM_AW-1:0]];
    endcase
  end

  // ==========================================================
  // AXI4-Lite channels; address and data are taken in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next  = read_word(s_axi_araddr);
      rresp_next  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // ==========================================================
  // Host access engine, software registers and shared memory
  always_comb begin
    state_next      = state_reg;
    strb_d_next     = strb;
    as_d_next       = ~address_strobe_n;
    strap_next      = strap_reg;
    strap_done_next = strap_done_reg;
    acc_sel_next    = acc_sel_reg;
    acc_bil_next    = acc_bil_reg;
    acc_rnw_next    = acc_rnw_reg;
    wr_byte_next    = wr_byte_reg;
    wr_hi_next      = wr_hi_reg;
    rd_byte_next    = rd_byte_reg;
    shadow_next     = shadow_reg;
    haddr_next      = haddr_reg;
    int_flag_next   = int_flag_reg;
    holder_en_next  = holder_en_reg;
    gpio_mode_next  = gpio_mode_reg;
    gpio_dir_next   = gpio_dir_reg;
    gpio_out_next   = gpio_out_reg;
    busy_cnt_next   = busy_cnt_reg;
    mem_next        = mem_reg;
    // Strap is caught once, on the first edge after reset release
    if (!strap_done_reg) begin
      strap_done_next = 1'b1;
      strap_next      = port_enable_strap;
    end
    // Software side writes
    if (wr_fire) begin
      if (aw_addr_reg[7:6] == MEM_PAGE) begin
        mem_next[aw_addr_reg[MEM_AW+1:2]] = wr_word[15:0];
      end else begin
        case ({aw_addr_reg[7:2], 2'b00})
          OFS_BANK_CTRL: holder_en_next = wr_word[BIT_HOLDER];
          OFS_GPIO_CTRL: begin
            gpio_mode_next = wr_word[BIT_GPIO_MODE];
            gpio_dir_next  = wr_word[GPIO_DIR_LSB+7:GPIO_DIR_LSB];
          end
          OFS_GPIO_DATA: gpio_out_next = wr_word[7:0];
          OFS_HOST_ADDR: haddr_next = wr_word[15:0];
          default:       gpio_out_next = gpio_out_reg;
        endcase
      end
    end
    // Multiplexed hosts put the address on the data bus
    if (host_on && sel && as_fall) begin
      if (byte_identify) begin
        haddr_next[7:0] = host_data_in;
      end else begin
        haddr_next[15:8] = host_data_in;
      end
    end
    case (state_reg)
      HS_IDLE: begin
        // A strobe that starts while busy is ignored; host must wait for ready
        if (host_on && start) begin
          acc_sel_next = live_sel;
          acc_bil_next = byte_identify;
          acc_rnw_next = read_not_write;
          if (read_not_write) begin
            // First byte is the high half; second comes from the snapshot
            rd_byte_next = byte_identify ? shadow_reg[7:0] : host_word[15:8];
            if (!byte_identify) begin
              shadow_next = host_word;
            end
          end
          state_next = HS_ACTIVE;
        end
      end
      HS_ACTIVE: begin
        if (strb) begin
          wr_byte_next = host_data_in;
        end
        if (stop) begin
          if (!acc_bil_reg) begin
            if (!acc_rnw_reg) begin
              wr_hi_next = wr_byte_reg;
            end
            state_next = HS_IDLE;
          end else begin
            if (!acc_rnw_reg) begin
              case (acc_sel_reg)
                SEL_CTRL: begin
                  if (wr_byte_reg[CTRL_INT_BIT]) begin
                    int_flag_next = 1'b0;
                  end
                end
                SEL_ADDR: haddr_next = {wr_hi_reg, wr_byte_reg};
                default:  mem_next[haddr_reg[MEM_AW-1:0]] = {wr_hi_reg, wr_byte_reg};
              endcase
            end
            if (acc_sel_reg == SEL_DATA_INC) begin
              haddr_next = haddr_reg + 16'h0001;
            end
            busy_cnt_next = BUSY_LOAD;
            state_next    = HS_BUSY;
          end
        end
      end
      HS_BUSY: begin
        busy_cnt_next = busy_cnt_reg - 3'h1;
        if (busy_cnt_reg == 3'h1) begin
          state_next = HS_IDLE;
        end
      end
      default: state_next = HS_IDLE;
    endcase
    // Software raise beats a host clear in the same cycle
    if (wr_fire && aw_addr_reg[7:6] != MEM_PAGE &&
        {aw_addr_reg[7:2], 2'b00} == OFS_HOST_CTRL && wr_word[CTRL_INT_BIT]) begin
      int_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg      <= HS_IDLE;
      strb_d_reg     <= 1'b0;
      as_d_reg       <= 1'b0;
      strap_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
      acc_sel_reg    <= 2'h0;
      acc_bil_reg    <= 1'b0;
      acc_rnw_reg    <= 1'b0;
      wr_byte_reg    <= 8'h00;
      wr_hi_reg      <= 8'h00;
      rd_byte_reg    <= 8'h00;
      shadow_reg     <= 16'h0000;
      haddr_reg      <= 16'h0000;
      int_flag_reg   <= 1'b0;
      holder_en_reg  <= 1'b0;
      gpio_mode_reg  <= 1'b0;
      gpio_dir_reg   <= 8'h00;
      gpio_out_reg   <= 8'h00;
      busy_cnt_reg   <= 3'h0;
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_reg[i] <= 16'h0000;
      end
    end else begin
      state_reg      <= state_next;
      strb_d_reg     <= strb_d_next;
      as_d_reg       <= as_d_next;
      strap_reg      <= strap_next;
      strap_done_reg <= strap_done_next;
      acc_sel_reg    <= acc_sel_next;
      acc_bil_reg    <= acc_bil_next;
      acc_rnw_reg    <= acc_rnw_next;
      wr_byte_reg    <= wr_byte_next;
      wr_hi_reg      <= wr_hi_next;
      rd_byte_reg    <= rd_byte_next;
      shadow_reg     <= shadow_next;
      haddr_reg      <= haddr_next;
      int_flag_reg   <= int_flag_next;
      holder_en_reg  <= holder_en_next;
      gpio_mode_reg  <= gpio_mode_next;
      gpio_dir_reg   <= gpio_dir_next;
      gpio_out_reg   <= gpio_out_next;
      busy_cnt_reg   <= busy_cnt_next;
      mem_reg        <= mem_next;
    end
  end

  // ==========================================================
  // Pin drivers; emulation-off floats the data, ready and interrupt drivers but not the holders
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      drive_en[i] = emulation_off_n & (gpio_mode_reg ? gpio_dir_reg[i] :
                    (host_on & strb & acc_rnw_reg & (state_reg == HS_ACTIVE)));
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_pin
    data_pin_cell u_pin (
      .clk       (clk),
      .rst       (rst),
      .pin_in    (host_data_in[g]),
      .pin_out   (host_data_out[g]),
      .pin_oe    (host_data_oe[g]),
      .hold_out  (holder_out[g]),
      .hold_oe   (holder_oe[g]),
      .drive_en  (drive_en[g]),
      .drive_val (gpio_mode_reg ? gpio_out_reg[g] : rd_byte_reg[g]),
      .holder_en (holder_en_reg)
    );
  end

  assign transfer_ready_out = (state_reg != HS_BUSY);
  assign transfer_ready_oe  = emulation_off_n;
  assign host_interrupt_out = ~int_flag_reg;
  assign host_interrupt_oe  = emulation_off_n;
  assign pullup_enable      = ~port_enable_strap;

  // ==========================================================
  // Checks
  a_float_off: assert property (@(posedge clk) disable iff (rst)
    !emulation_off_n |-> host_data_oe == 8'h00)
    else $error("data bus driven while emulation-off low");
  a_drive_read: assert property (@(posedge clk) disable iff (rst)
    (host_data_oe != 8'h00 && !gpio_mode_reg) |-> (acc_rnw_reg && strb))
    else $error("data bus driven outside a read");
  a_holder_reset: assert property (@(posedge clk)
    $fell(rst) |-> !holder_en_reg && holder_oe == 8'h00)
    else $error("holders enabled out of reset");
  a_ready_busy: assert property (@(posedge clk) disable iff (rst)
    (state_reg == HS_ACTIVE && stop && acc_bil_reg) |=>
      !transfer_ready_out [*2] ##1 transfer_ready_out)
    else $error("ready not low for busy time");
  a_int_reset: assert property (@(posedge clk) rst |-> host_interrupt_out)
    else $error("interrupt low during reset");
  a_pullup_strap: assert property (@(posedge clk) disable iff (rst)
    $changed(port_enable_strap) |-> $changed(pullup_enable) && pullup_enable != port_enable_strap)
    else $error("pull-ups not following strap");
  a_addr_latch: assert property (@(posedge clk) disable iff (rst)
    (host_on && sel && as_fall && !byte_identify && state_reg != HS_ACTIVE && !wr_fire) |=>
      haddr_reg[15:8] == $past(host_data_in))
    else $error("address high byte not latched");
  a_word_pair: assert property (@(posedge clk) disable iff (rst)
    (state_reg == HS_ACTIVE && stop && acc_bil_reg && !acc_rnw_reg && acc_sel_reg[1] &&
     acc_sel_reg[0]) |=> mem_reg[$past(haddr_reg[MEM_AW-1:0])] == {$past(wr_hi_reg), $past(wr_byte_reg)})
    else $error("byte pair not assembled into word");
  a_gpio_drive: assert property (@(posedge clk) disable iff (rst)
    (gpio_mode_reg && emulation_off_n) |-> host_data_oe == gpio_dir_reg)
    else $error("gpio direction not on pins");
  a_idle_start: assert property (@(posedge clk) disable iff (rst)
    (state_reg == HS_IDLE && !strb) |=> state_reg != HS_ACTIVE)
    else $error("access began without a strobe");
endmodule

// ### tb/host_model.sv
// Host processor model that drives the parallel port pins
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic       clk,
  // Device pin side
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe,
  input  wire logic [7:0] hold_out,
  input  wire logic [7:0] hold_oe,
  input  wire logic       ready,
  // Host strobes and resolved bus
  output logic            sel_lo,
  output logic            sel_hi,
  output logic            bi,
  output logic            cs_n,
  output logic            ds_a_n,
  output logic            ds_b_n,
  output logic            rnw,
  output logic            as_n,
  output logic [7:0]      level
);
  logic [7:0] drv = '0;
  logic       drv_on = 1'b0;
  logic [7:0] last = '0;
  initial begin
    {sel_lo, sel_hi, bi, rnw} = '0;
    {cs_n, ds_a_n, ds_b_n, as_n} = 4'hF;
  end
  // A pin nobody drives shows the inverse of its last level, so a lost holder is seen
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = dev_oe[i] ? dev_out[i] : drv_on ? drv[i] : hold_oe[i] ? hold_out[i] : ~last[i];
    end
  end
  always @(posedge clk) last <= level;
  // One byte access: wait for ready, strobe three cycles, release, then watch busy
  task automatic xfer(input logic [1:0] s, input logic b, input logic r, input logic [7:0] wd,
                      output logic [15:0] rd, output int nb);
    do @(negedge clk); while (ready !== 1'b1);
    @(posedge clk);
    {sel_hi, sel_lo} <= s;
    bi <= b;
    rnw <= r;
    cs_n <= 1'b0;
    ds_a_n <= r;
    ds_b_n <= ~r;
    drv <= wd;
    drv_on <= ~r;
    repeat (3) @(negedge clk);
    rd = {dev_oe, level};
    @(posedge clk);
    {cs_n, ds_a_n, ds_b_n, drv_on} <= 4'hE;
    nb = 0;
    repeat (4) begin
      @(negedge clk);
      nb += int'(ready === 1'b0);
    end
    @(posedge clk);
  endtask
  // Multiplexed address phase: one address strobe per byte, high byte first
  task automatic addr_phase(input logic [15:0] a);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      bi <= j[0];
      cs_n <= 1'b0;
      as_n <= 1'b0;
      drv <= j[0] ? a[7:0] : a[15:8];
      drv_on <= 1'b1;
      @(posedge clk);
      {cs_n, as_n, drv_on} <= 3'h6;
    end
    @(posedge clk);
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the host parallel port
`timescale 1ns/100ps
module testbench;
  import hpp_pkg::*;
  logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, port_enable_strap = 1;
  logic emulation_off_n = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, register_select_lo, register_select_hi, byte_identify, port_select_n;
  logic data_strobe_a_n, data_strobe_b_n, read_not_write, transfer_ready_out, address_strobe_n;
  logic transfer_ready_oe, host_interrupt_out, host_interrupt_oe, pullup_enable;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r2;
  logic [7:0] host_data_in, host_data_out, host_data_oe, holder_out, holder_oe;
  logic [15:0] rd, a16;
  logic [7:0] g8;
  int mismatches = 0, n_tests = 0, cyc = 0, nb;
  int mem [16];
  always #2.5 clk = ~clk;
  host_port host_port_i (.*);
  host_model host_model_i (.clk(clk), .dev_out(host_data_out), .dev_oe(host_data_oe),
    .hold_out(holder_out), .hold_oe(holder_oe), .ready(transfer_ready_out),
    .sel_lo(register_select_lo), .sel_hi(register_select_hi), .bi(byte_identify),
    .cs_n(port_select_n), .ds_a_n(data_strobe_a_n), .ds_b_n(data_strobe_b_n),
    .rnw(read_not_write), .as_n(address_strobe_n), .level(host_data_in));
  // ==========================================================
  // Compare, report and close
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard: whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // AXI4-Lite master; ready is sampled at the negedge so release follows the taking edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] br;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      {tb, br} = {s_axi_bvalid, s_axi_bresp};
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
    // One idle edge so a following call never reassigns bready in this step
    @(posedge clk);
    check(br, RESP_OKAY);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tb;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      {tb, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tb);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(59));
    repeat (4) @(negedge clk);
    check(host_interrupt_out, 1);
    check(host_data_oe, 0);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    axi_rd(OFS_BANK_CTRL, v, r2); check(v, 0);
    axi_rd(8'h20, v, r2); check(r2, RESP_SLVERR);
    // Host writes a word, software reads it; software writes, host reads with autoincrement
    for (int k = 0; k < 4; k++) begin
      mem[k] = int'($urandom & 32'hFFFF);
      axi_wr(OFS_HOST_ADDR, k);
      host_model_i.xfer(2'h3, 0, 0, 8'(mem[k] >> 8), rd, nb); check({rd[15:8], 8'(nb)}, 0);
      host_model_i.xfer(2'h3, 1, 0, 8'(mem[k]), rd, nb); check(nb, 2);
      axi_rd(8'(8'h40 + 4 * k), v, r2); check(v, mem[k]);
      mem[k] = mem[k] ^ 32'hA5C3;
      axi_wr(8'(8'h40 + 4 * k), mem[k]);
      host_model_i.xfer(2'h1, 0, 1, 0, rd, nb); check(rd, {8'hFF, 8'(mem[k] >> 8)});
      host_model_i.xfer(2'h1, 1, 1, 0, rd, nb); check(rd, {8'hFF, 8'(mem[k])});
      axi_rd(OFS_HOST_ADDR, v, r2); check(v, k + 1);
    end
    // Holders keep the last driven byte once enabled
    axi_wr(OFS_BANK_CTRL, 1);
    axi_rd(OFS_BANK_CTRL, v, r2); check(v, 1);
    axi_wr(OFS_HOST_ADDR, 0);
    host_model_i.xfer(2'h3, 0, 1, 0, rd, nb);
    check({holder_oe, holder_out}, {8'hFF, 8'(mem[0] >> 8)});
    emulation_off_n <= 1'b0;
    host_model_i.xfer(2'h3, 1, 1, 0, rd, nb);
    check({rd[15:8], transfer_ready_oe, host_interrupt_oe}, 0);
    emulation_off_n <= 1'b1;
    // Multiplexed address phase, then the host reads the address register back
    a16 = 16'($urandom);
    host_model_i.addr_phase(a16);
    axi_rd(OFS_HOST_ADDR, v, r2); check(v, a16);
    host_model_i.xfer(2'h2, 0, 1, 0, rd, nb); check(rd, {8'hFF, a16[15:8]});
    host_model_i.xfer(2'h2, 1, 1, 0, rd, nb); check(rd, {8'hFF, a16[7:0]});
    // Software raises the interrupt, a host control write clears it
    axi_wr(OFS_HOST_CTRL, 8);
    @(negedge clk); check(host_interrupt_out, 0);
    host_model_i.xfer(2'h0, 0, 0, 0, rd, nb);
    host_model_i.xfer(2'h0, 1, 0, 8'h08, rd, nb); check(host_interrupt_out, 1);
    // Pins as general-purpose I/O: upper nibble driven, lower nibble left to holders
    g8 = 8'($urandom);
    axi_wr(OFS_GPIO_DATA, g8);
    axi_wr(OFS_GPIO_CTRL, 32'h0000F001);
    @(negedge clk); check({host_data_oe, host_data_out}, {8'hF0, g8});
    @(posedge clk);
    axi_rd(OFS_GPIO_DATA, v, r2); check({v[15:12], v[7:0]}, {g8[7:4], g8});
    axi_wr(OFS_GPIO_CTRL, 0);
    check(pullup_enable, 0);
    port_enable_strap <= 1'b0;
    @(negedge clk); check(pullup_enable, 1);
    tally_and_finish();
  end
endmodule
